// ===== rtl/dt_regs.vh
// dtmf transceiver constants: register map, fields, timing
// Functional notes
// - each tone period is 32 equal segments; divider count sets segment length
// - divider terminal count restarts it and advances the sine table counter
// - two identical channels make row and column tones, outputs summed
// - divider and sine counter restart on burst start so a burst starts on its first segment
// - dual-tone burst mode: 51 ms burst then equal 51 ms pause
// - after burst and pause complete, set transmitter-ready status flag
// - call-progress burst mode doubles burst and pause to 102 ms
// - call-progress plus burst mode: transmit only, no receive latching
// - single-tone mode emits one low-group or high-group tone only
// - tone lost before presence guard time leaves receive data unchanged
// - tone present full presence guard time: latch 4-bit code
// - after absence guard time, latched code held until next valid tone
// - dropout shorter than absence guard changes nothing, no new detect
// - status b3 low while validated signal present, moves after guard time
// - status b2 set on new latched code, cleared by status read
// - interrupt active on new receive data, released by status read
// - one shared 4-bit code for transmit and receive digit registers
// - mode bit 0 dual-tone, 1 call-progress; tones shown on interrupt pin
// - dual-tone interrupt on valid digit or, in burst, transmitter ready
`ifndef DT_REGS_VH
`define DT_REGS_VH
// apb byte addresses
`define DT_ADDR_TXDATA 8'h00
`define DT_ADDR_RXDATA 8'h04
`define DT_ADDR_CTRL 8'h08
`define DT_ADDR_STATUS 8'h0C
// control fields
`define DT_CTRL_TONE 0
`define DT_CTRL_CP 1
`define DT_CTRL_IRQ 2
`define DT_CTRL_BURST 3
`define DT_CTRL_SINGLE 4
`define DT_CTRL_SHIGH 5
`define DT_CTRL_W 6
`define DT_CTRL_RST 6'h00
// status fields
`define DT_ST_IRQ 0
`define DT_ST_TXRDY 1
`define DT_ST_RXVAL 2
`define DT_ST_DSTEER 3
// timing
`define DT_CLK_MHZ 50
`define DT_BURST_MS 51
`define DT_GTP_US 40000
`define DT_GTA_US 40000
`define DT_SEGMENTS 32
// segment divider counts: 50 MHz / (f * 32)
`define DT_DIV_697 12'd2242
`define DT_DIV_770 12'd2029
`define DT_DIV_852 12'd1834
`define DT_DIV_941 12'd1660
`define DT_DIV_1209 12'd1292
`define DT_DIV_1336 12'd1169
`define DT_DIV_1477 12'd1058
`define DT_DIV_1633 12'd957
`define DT_MIDSCALE 8'h80
`define DT_OUT_IDLE 9'h100
`endif

// ===== rtl/dt_transceiver.v
// dtmf transceiver digital core with apb register port
//
// Implementation choices: the APB interface to the registers and the address map.
`timescale 1ns/10ps
`include "dt_regs.vh"
module dt_transceiver #(
  parameter BURST_CYC = `DT_BURST_MS * 1000 * `DT_CLK_MHZ,
  parameter PRES_CYC = `DT_GTP_US * `DT_CLK_MHZ,
  parameter ABS_CYC = `DT_GTA_US * `DT_CLK_MHZ
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // apb slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // receiver front end
  input wire early_steering_out,
  input wire [3:0] rx_code_in,
  input wire cp_tone_in,
  output wire steering_guard_pin,
  // transmitter
  output reg [8:0] tone_dac_out,
  output wire tone_active,
  // open-drain interrupt / tone pin
  input wire interrupt_or_tone_pin_i,
  output wire interrupt_or_tone_pin_o,
  output wire interrupt_or_tone_pin_oe
);

  localparam ST_IDLE = 2'd0;
  localparam ST_BURST = 2'd1;
  localparam ST_PAUSE = 2'd2;

  // low group index from digit code
  function [1:0] dt_low_idx;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h2, 4'h3, 4'hD: dt_low_idx = 2'd0;
        4'h4, 4'h5, 4'h6, 4'hE: dt_low_idx = 2'd1;
        4'h7, 4'h8, 4'h9, 4'hF: dt_low_idx = 2'd2;
        default: dt_low_idx = 2'd3;
      endcase
    end
  endfunction

  // high group index from digit code
  function [1:0] dt_high_idx;
    input [3:0] code;
    begin
      case (code)
        4'h1, 4'h4, 4'h7, 4'hB: dt_high_idx = 2'd0;
        4'h2, 4'h5, 4'h8, 4'hA: dt_high_idx = 2'd1;
        4'h3, 4'h6, 4'h9, 4'hC: dt_high_idx = 2'd2;
        default: dt_high_idx = 2'd3;
      endcase
    end
  endfunction

  // segment length per tone
  function [11:0] dt_div;
    input [2:0] sel;
    begin
      case (sel)
        3'd0: dt_div = `DT_DIV_697;
        3'd1: dt_div = `DT_DIV_770;
        3'd2: dt_div = `DT_DIV_852;
        3'd3: dt_div = `DT_DIV_941;
        3'd4: dt_div = `DT_DIV_1209;
        3'd5: dt_div = `DT_DIV_1336;
        3'd6: dt_div = `DT_DIV_1477;
        default: dt_div = `DT_DIV_1633;
      endcase
    end
  endfunction

  // sine table, quarter wave mirrored to 32 entries
  function [7:0] dt_sine;
    input [4:0] ph;
    reg [3:0] q;
    reg [7:0] m;
    begin
      q = ph[3] ? (4'd0 - ph[3:0]) : ph[3:0];
      if (ph[3] && ph[2:0] == 3'd0) begin
        q = 4'd8;
      end
      case (q)
        4'd0: m = 8'h00;
        4'd1: m = 8'h19;
        4'd2: m = 8'h31;
        4'd3: m = 8'h47;
        4'd4: m = 8'h5A;
        4'd5: m = 8'h6A;
        4'd6: m = 8'h75;
        4'd7: m = 8'h7D;
        default: m = 8'h7F;
      endcase
      dt_sine = ph[4] ? (`DT_MIDSCALE - m) : (`DT_MIDSCALE + m);
    end
  endfunction

  // apb access qualifiers
  wire apb_setup = psel & ~penable;
  wire apb_acc = psel & penable;
  wire hit_tx = (paddr == `DT_ADDR_TXDATA);
  wire hit_rx = (paddr == `DT_ADDR_RXDATA);
  wire hit_ctrl = (paddr == `DT_ADDR_CTRL);
  wire hit_st = (paddr == `DT_ADDR_STATUS);
  wire wr_tx = apb_acc & pwrite & hit_tx;
  wire wr_ctrl = apb_acc & pwrite & hit_ctrl;
  wire rd_st = apb_acc & ~pwrite & hit_st;
  reg addr_bad;

  always @* begin
    if (hit_tx) begin
      addr_bad = ~pwrite;
    end else if (hit_rx) begin
      addr_bad = pwrite;
    end else if (hit_ctrl) begin
      addr_bad = 1'b0;
    end else if (hit_st) begin
      addr_bad = pwrite;
    end else begin
      addr_bad = 1'b1;
    end
  end

  assign pready = 1'b1;
  assign pslverr = apb_acc & addr_bad;

  // control and data registers
  reg [`DT_CTRL_W-1:0] ctrl_ff;
  reg [3:0] tx_code_ff;
  reg [3:0] rx_code_ff;
  reg rx_valid_ff;
  reg tx_ready_ff;
  wire tone_en = ctrl_ff[`DT_CTRL_TONE];
  wire cp_mode = ctrl_ff[`DT_CTRL_CP];
  wire irq_en = ctrl_ff[`DT_CTRL_IRQ];
  wire burst_mode = ctrl_ff[`DT_CTRL_BURST];
  wire single_mode = ctrl_ff[`DT_CTRL_SINGLE];
  wire single_high = ctrl_ff[`DT_CTRL_SHIGH];
  wire rx_block = cp_mode & burst_mode;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ff <= `DT_CTRL_RST;
      tx_code_ff <= 4'h0;
    end else begin
      if (wr_ctrl) begin
        ctrl_ff <= pwdata[`DT_CTRL_W-1:0];
      end
      if (wr_tx) begin
        tx_code_ff <= pwdata[3:0];
      end
    end
  end

  // receiver input synchronisers
  reg [1:0] est_sync_ff;
  reg [3:0] code_s1_ff;
  reg [3:0] code_s2_ff;
  reg [1:0] cpt_sync_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      est_sync_ff <= 2'b00;
      code_s1_ff <= 4'h0;
      code_s2_ff <= 4'h0;
      cpt_sync_ff <= 2'b00;
    end else begin
      est_sync_ff <= {est_sync_ff[0], early_steering_out};
      code_s1_ff <= rx_code_in;
      code_s2_ff <= code_s1_ff;
      cpt_sync_ff <= {cpt_sync_ff[0], cp_tone_in};
    end
  end

  wire tone_seen = est_sync_ff[1];

  // steering guard: presence and absence timing
  reg steer_ff;
  reg [31:0] guard_cnt_ff;
  wire rx_latch = ~rx_block & ~steer_ff & tone_seen & (guard_cnt_ff == PRES_CYC - 1);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      steer_ff <= 1'b0;
      guard_cnt_ff <= 32'h0;
    end else if (rx_block) begin
      guard_cnt_ff <= 32'h0;
    end else if (!steer_ff) begin
      if (!tone_seen) begin
        guard_cnt_ff <= 32'h0;
      end else if (rx_latch) begin
        steer_ff <= 1'b1;
        guard_cnt_ff <= 32'h0;
      end else begin
        guard_cnt_ff <= guard_cnt_ff + 32'h1;
      end
    end else begin
      if (tone_seen) begin
        guard_cnt_ff <= 32'h0;
      end else if (guard_cnt_ff == ABS_CYC - 1) begin
        steer_ff <= 1'b0;
        guard_cnt_ff <= 32'h0;
      end else begin
        guard_cnt_ff <= guard_cnt_ff + 32'h1;
      end
    end
  end

  assign steering_guard_pin = steer_ff;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_code_ff <= 4'h0;
    end else if (rx_latch) begin
      rx_code_ff <= code_s2_ff;
    end
  end

  // burst / pause sequencer
  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [31:0] burst_cnt_ff;
  wire [31:0] burst_len = cp_mode ? (BURST_CYC * 2) : BURST_CYC;
  wire burst_end = (burst_cnt_ff == burst_len - 1);
  wire burst_start = wr_tx & burst_mode;
  wire pause_done = (state_ff == ST_PAUSE) & burst_end;

  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (burst_start) begin
          nxt_state = ST_BURST;
        end
      end
      ST_BURST: begin
        if (!burst_mode) begin
          nxt_state = ST_IDLE;
        end else if (burst_end) begin
          nxt_state = ST_PAUSE;
        end
      end
      ST_PAUSE: begin
        if (!burst_mode || burst_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= ST_IDLE;
      burst_cnt_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      if (nxt_state != state_ff || state_ff == ST_IDLE) begin
        burst_cnt_ff <= 32'h0;
      end else begin
        burst_cnt_ff <= burst_cnt_ff + 32'h1;
      end
    end
  end

  // status flags: a read clears only bits it returned set, burst start also clears tx ready, and set wins
  wire clr_rx = rd_st & prdata[`DT_ST_RXVAL];
  wire clr_tx = rd_st & prdata[`DT_ST_TXRDY];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_valid_ff <= 1'b0;
      tx_ready_ff <= 1'b0;
    end else begin
      if (rx_latch) begin
        rx_valid_ff <= 1'b1;
      end else if (clr_rx) begin
        rx_valid_ff <= 1'b0;
      end
      if (pause_done) begin
        tx_ready_ff <= 1'b1;
      end else if (clr_tx || burst_start) begin
        tx_ready_ff <= 1'b0;
      end
    end
  end

  // interrupt pin: active low open drain
  wire irq_dtmf = rx_valid_ff | (burst_mode & tx_ready_ff);
  wire irq_act = irq_en & (cp_mode ? ~cpt_sync_ff[1] : irq_dtmf);
  assign interrupt_or_tone_pin_o = 1'b0;
  assign interrupt_or_tone_pin_oe = irq_act;

  // apb read data, captured in setup so a status read sees a stable snapshot
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      if (hit_rx) begin
        prdata <= {28'h0, rx_code_ff};
      end else if (hit_ctrl) begin
        prdata <= {{(32-`DT_CTRL_W){1'b0}}, ctrl_ff};
      end else if (hit_st) begin
        prdata <= {28'h0, ~steer_ff, rx_valid_ff, tx_ready_ff, irq_act};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  // tone gating: continuous tone, or burst phase only
  wire tone_on = tone_en & (~burst_mode | (state_ff == ST_BURST));
  assign tone_active = tone_on;
  wire [1:0] lo_idx = dt_low_idx(tx_code_ff);
  wire [1:0] hi_idx = dt_high_idx(tx_code_ff);
  wire [7:0] samp0;
  wire [7:0] samp1;
  wire [15:0] samp_bus;

  // two identical synthesiser channels
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
      reg [11:0] div_ff;
      reg [4:0] phase_ff;
      wire [2:0] sel = (gi == 0) ? {1'b0, lo_idx} : {1'b1, hi_idx};
      wire [11:0] div_top = dt_div(sel) - 12'd1;
      wire ch_on = ~single_mode | (single_high == (gi == 1));
      // restart on burst start so the first segment is a full one
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          div_ff <= 12'h000;
          phase_ff <= 5'h00;
        end else if (burst_start) begin
          div_ff <= 12'h000;
          phase_ff <= 5'h00;
        end else if (div_ff >= div_top) begin
          div_ff <= 12'h000;
          phase_ff <= phase_ff + 5'h01;
        end else begin
          div_ff <= div_ff + 12'h001;
        end
      end
      assign samp_bus[gi*8 +: 8] = ch_on ? dt_sine(phase_ff) : `DT_MIDSCALE;
    end
  endgenerate

  assign samp0 = samp_bus[7:0];
  assign samp1 = samp_bus[15:8];

  // summed dual-tone output, midscale when gated off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tone_dac_out <= `DT_OUT_IDLE;
    end else if (tone_on) begin
      tone_dac_out <= {1'b0, samp0} + {1'b0, samp1};
    end else begin
      tone_dac_out <= `DT_OUT_IDLE;
    end
  end

endmodule // dt_transceiver

// ===== tb/dt_detector_model.sv
// tone detector front end model feeding the receiver
`timescale 1ns/10ps
module dt_detector_model (
  // clock
  input wire logic pclk,
  // scenario control
  input wire logic tone_on,
  input wire logic [3:0] code,
  // detector outputs
  output logic early_steering_out,
  output logic [3:0] rx_code_in
);
  initial begin
    early_steering_out = 1'b0;
    rx_code_in = 4'h0;
  end
  // code is only valid with a tone, so it churns otherwise
  always @(posedge pclk) begin
    early_steering_out <= tone_on;
    if (tone_on) begin
      rx_code_in <= code;
    end else begin
      rx_code_in <= ~rx_code_in;
    end
  end
endmodule // dt_detector_model

// ===== tb/dt_transceiver_properties.sv
// concurrent checks on the transceiver ports
`timescale 1ns/10ps
module dt_transceiver_checker #(
  parameter PRES_CYC = 50,
  parameter ABS_CYC = 50
) (
  input logic pclk,
  input logic presetn,
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  input logic early_steering_out,
  input logic steering_guard_pin,
  input logic [8:0] tone_dac_out,
  input logic tone_active
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  int hi_ff;
  int lo_ff;
  // run lengths of the raw detector level
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hi_ff <= 0;
      lo_ff <= 0;
    end else begin
      hi_ff <= early_steering_out ? hi_ff + 1 : 0;
      lo_ff <= early_steering_out ? 0 : lo_ff + 1;
    end
  end
  a_zero_wait: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  a_unmapped_err: assert property (psel && penable
    && !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> pslverr)
    else $error("unmapped access not refused");
  a_wrong_dir: assert property (psel && penable && ((pwrite && (paddr == 8'h04
    || paddr == 8'h0C)) || (!pwrite && paddr == 8'h00)) |-> pslverr)
    else $error("wrong direction not refused");
  a_err_in_access: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_upper_zero: assert property (psel && penable && !pwrite |-> (paddr == 8'h08)
    ? (prdata[31:6] == 26'h0) : (prdata[31:4] == 28'h0))
    else $error("upper read bits not zero");
  a_presence_guard: assert property ($rose(steering_guard_pin) |-> hi_ff >= PRES_CYC)
    else $error("steering rose before presence guard");
  a_absence_guard: assert property ($fell(steering_guard_pin) |-> lo_ff >= ABS_CYC)
    else $error("steering fell before absence guard");
  a_idle_output: assert property (!tone_active [*3] |-> tone_dac_out == 9'h100)
    else $error("tone output not idle while disabled");
endmodule // dt_transceiver_checker
bind dt_transceiver dt_transceiver_checker #(.PRES_CYC(PRES_CYC), .ABS_CYC(ABS_CYC)) chk_i (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .early_steering_out(early_steering_out), .steering_guard_pin(steering_guard_pin),
  .tone_dac_out(tone_dac_out), .tone_active(tone_active));

// ===== tb/testbench.sv
// self-checking bench for the dtmf transceiver core
`timescale 1ns/10ps
module testbench;
  typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] r; logic e;} dt_row_t;
  logic pclk, presetn, psel, penable, pwrite, tone_on, cp_tone_in, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, steering_guard_pin, tone_active, pin_o, pin_oe;
  logic early_steering_out;
  logic [3:0] rx_code_in, code;
  logic [8:0] tone_dac_out, dac_old;
  wire pin_i = !pin_oe;
  int fails, total_checks, n, m;
  dt_row_t rows [8];
  dt_transceiver #(.BURST_CYC(200), .PRES_CYC(50), .ABS_CYC(50)) dt_transceiver_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .early_steering_out(early_steering_out), .rx_code_in(rx_code_in),
    .cp_tone_in(cp_tone_in), .steering_guard_pin(steering_guard_pin),
    .tone_dac_out(tone_dac_out), .tone_active(tone_active),
    .interrupt_or_tone_pin_i(pin_i), .interrupt_or_tone_pin_o(pin_o),
    .interrupt_or_tone_pin_oe(pin_oe));
  dt_detector_model dt_detector_model_i (.pclk(pclk), .tone_on(tone_on), .code(code),
    .early_steering_out(early_steering_out), .rx_code_in(rx_code_in));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // bounded wait on a level, cycles waited in n
  task automatic wait_for(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v) begin
      @(posedge pclk);
      n++;
      if (n > lim) begin
        fails++;
        wrap_up();
      end
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (k = 0; k < 20; k++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (k == 20) begin
      fails++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    tone_on = 1'b0;
    code = 4'h0;
    cp_tone_in = 1'b1;
    rows = '{'{1'b0, 8'h08, 32'h0, 32'h0, 1'b0}, '{1'b0, 8'h0C, 32'h0, 32'h8, 1'b0},
      '{1'b1, 8'h08, 32'h3F, 32'h0, 1'b0}, '{1'b0, 8'h08, 32'h0, 32'h3F, 1'b0},
      '{1'b0, 8'h00, 32'h0, 32'h0, 1'b1}, '{1'b1, 8'h04, 32'h5, 32'h0, 1'b1},
      '{1'b1, 8'h0C, 32'hF, 32'h0, 1'b1}, '{1'b0, 8'h10, 32'h0, 32'h0, 1'b1}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w) chk(rd, rows[i].r);
      chk({31'h0, err}, {31'h0, rows[i].e});
    end
    $display("register table done");
    apb(1'b1, 8'h08, 32'h04);
    code <= 4'h5;
    tone_on <= 1'b1;
    repeat (20) @(posedge pclk);
    tone_on <= 1'b0;
    repeat (60) @(posedge pclk);
    chk(steering_guard_pin, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h0);
    tone_on <= 1'b1;
    wait_for(steering_guard_pin, 1'b1, 80);
    chk(n >= 50, 1'b1);
    chk({pin_oe, pin_o}, 2'b10);
    tone_on <= 1'b0;
    repeat (20) @(posedge pclk);
    tone_on <= 1'b1;
    repeat (20) @(posedge pclk);
    chk(steering_guard_pin, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h5);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h5);
    chk(pin_oe, 1'b0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h0);
    tone_on <= 1'b0;
    wait_for(steering_guard_pin, 1'b0, 80);
    chk(n >= 50, 1'b1);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h8);
    $display("receive test done");
    apb(1'b1, 8'h08, 32'h0A);
    code <= 4'h9;
    tone_on <= 1'b1;
    repeat (80) @(posedge pclk);
    tone_on <= 1'b0;
    chk(steering_guard_pin, 1'b0);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'h5);
    apb(1'b1, 8'h08, 32'h06);
    cp_tone_in <= 1'b0;
    repeat (5) @(posedge pclk);
    chk(pin_oe, 1'b1);
    cp_tone_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chk(pin_oe, 1'b0);
    $display("call progress test done");
    // free running tone: the high segment of digit 1 is under 1300 cycles
    apb(1'b1, 8'h08, 32'h01);
    apb(1'b1, 8'h00, 32'h1);
    repeat (5) @(posedge pclk);
    dac_old = tone_dac_out;
    repeat (1400) @(posedge pclk);
    chk(tone_dac_out != dac_old, 1'b1);
    chk(tone_active, 1'b1);
    apb(1'b1, 8'h08, 32'h00);
    repeat (4) @(posedge pclk);
    chk({tone_active, tone_dac_out}, 10'h100);
    $display("tone test done");
    // burst start restarts both phases; at 1700 cycles only the high channel has stepped
    for (m = 0; m < 2; m++) begin
      apb(1'b1, 8'h08, m ? 32'h38 : 32'h18);
      apb(1'b1, 8'h00, 32'h1);
      apb(1'b1, 8'h08, m ? 32'h31 : 32'h11);
      repeat (1700) @(posedge pclk);
      chk(tone_dac_out != 9'h100, m);
    end
    $display("single tone test done");
    for (m = 0; m < 2; m++) begin
      apb(1'b1, 8'h08, m ? 32'h0F : 32'h0D);
      apb(1'b1, 8'h00, 32'h1);
      wait_for(tone_active, 1'b1, 5);
      wait_for(tone_active, 1'b0, 1000);
      chk(n >= (196 << m) && n <= (204 << m), 1'b1);
      repeat ((200 << m) - 12) @(posedge pclk);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[1], 1'b0);
      repeat (20) @(posedge pclk);
      chk(pin_oe, m == 0);
      apb(1'b0, 8'h0C, 32'h0);
      chk(rd[1], 1'b1);
      apb(1'b0, 8'h0C, 32'h0);
      chk({rd[1], pin_oe}, 2'b00);
    end
    $display("burst test done");
    // reset in mid-run with a tone playing
    apb(1'b1, 8'h08, 32'h01);
    repeat (3) @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({tone_active, tone_dac_out, steering_guard_pin, pin_oe}, 12'h400);
    presetn <= 1'b1;
    apb(1'b0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h0C, 32'h0);
    chk(rd, 32'h8);
    $display("reset test done");
    wrap_up();
  end
endmodule // testbench
